// ==== hdl/i2m_pkg.sv ====
// Constants and types of the I2C master command block
package i2m_pkg;
  // ---------------------------------------------------------------
  // Register map and command fields
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h0c;
  localparam logic [7:0] ADDR_TXD = 8'h10;
  localparam logic [7:0] ADDR_RXD = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  localparam logic [31:0] CMD_MASK = 32'h03ff_ffff;
  localparam int CMD_DIR = 0;
  localparam int CMD_A7_LSB = 1;
  localparam int CMD_A10_LSB = 8;
  localparam int CMD_SB = 11;
  localparam int CMD_AT_LSB = 12;
  localparam int CMD_STOP = 14;
  localparam int CMD_LEN_LSB = 15;
  localparam logic [1:0] AT_GCALL = 2'h0;
  localparam logic [1:0] AT_7 = 2'h1;
  localparam logic [1:0] AT_10 = 2'h2;
  localparam int ST_BUSY = 0;
  localparam int ST_NACK = 1;
  localparam int ST_PARKED = 2;
  localparam int ST_TXFULL = 3;
  localparam int ST_RXAVAIL = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ---------------------------------------------------------------
  // Bus bytes and timing
  // ---------------------------------------------------------------
  localparam logic [7:0] START_BYTE = 8'h01;
  localparam logic [7:0] GCALL_BYTE = 8'h00;
  localparam logic [4:0] TEN_HDR = 5'h1e;
  localparam int CLK_PS = 8000;
  localparam int SCL_PERIOD_NS = 125;
  localparam int QTR_CYC = (SCL_PERIOD_NS * 1000) / (4 * CLK_PS) > 0 ?
                           (SCL_PERIOD_NS * 1000) / (4 * CLK_PS) : 1;
  // ---------------------------------------------------------------
  // State encodings
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_START = 3'h1, S_BYTE = 3'h3, S_STOP = 3'h2,
    S_PARK = 3'h6
  } i2m_state_t;
  typedef enum logic [2:0] {
    P_SB = 3'h0, P_A1 = 3'h1, P_A2 = 3'h3, P_A3 = 3'h2, P_DATA = 3'h6
  } i2m_pos_t;
endpackage : i2m_pkg

// ==== hdl/i2m_master.sv ====
// I2C master command engine with AXI4-Lite registers and data FIFOs
`timescale 1ns/1ps
module i2m_master import i2m_pkg::*; #(
  parameter int TX_DEPTH = 8,
  parameter int RX_DEPTH = 8,
  parameter int QTR = QTR_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // I2C open-drain pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oen,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oen
);
  localparam int TAW = $clog2(TX_DEPTH);
  localparam int RAW = $clog2(RX_DEPTH);
  localparam int TW = $clog2(QTR + 1);

  i2m_state_t state;
  i2m_pos_t pos;
  logic [31:0] cmd;
  logic pending, nack, scl_drv, sda_drv, got_nack;
  logic [1:0] q;
  logic [3:0] bi;
  logic [TW-1:0] tmr;
  logic [7:0] sh, rx_sh, byte_out;
  logic [10:0] remain;
  logic [2:0] scl_s, sda_s;
  logic scl_f, sda_f;
  logic [7:0] tx_mem [TX_DEPTH];
  logic [7:0] rx_mem [RX_DEPTH];
  logic [TAW-1:0] tx_wp, tx_rp;
  logic [RAW-1:0] rx_wp, rx_rp;
  logic [TAW:0] tx_cnt;
  logic [RAW:0] rx_cnt;
  logic aw_full, w_full;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // ---------------------------------------------------------------
  // Command field decode
  // ---------------------------------------------------------------
  logic [1:0] at;
  logic [9:0] addr10;
  logic [10:0] len;
  logic is_rd, tx_empty, tx_full, rx_full, rx_empty;
  assign at = cmd[CMD_AT_LSB +: 2];
  assign addr10 = {cmd[CMD_A10_LSB +: 3], cmd[CMD_A7_LSB +: 7]};
  assign len = cmd[CMD_LEN_LSB +: 11];
  assign is_rd = cmd[CMD_DIR] && at != AT_GCALL;
  assign tx_empty = tx_cnt == '0;
  assign tx_full = tx_cnt == (TAW+1)'(TX_DEPTH);
  assign rx_empty = rx_cnt == '0;
  assign rx_full = rx_cnt == (RAW+1)'(RX_DEPTH);

  // ---------------------------------------------------------------
  // Pin synchronisers, change taken once stages two and three agree
  // ---------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
      if (scl_s[1] == scl_s[2]) scl_f <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_f <= sda_s[2];
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic do_write, can_cmd, wr_cmd, wr_txd, ar_hs, rd_rxd;
  assign s_axi_awready = !aw_full;
  assign s_axi_wready = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write = aw_full && w_full && !s_axi_bvalid;
  assign can_cmd = !pending && (state == S_IDLE || state == S_PARK);
  assign wr_cmd = do_write && aw_addr == ADDR_CMD && can_cmd;
  assign wr_txd = do_write && aw_addr == ADDR_TXD && w_strb[0] && !tx_full;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign rd_rxd = ar_hs && s_axi_araddr == ADDR_RXD && !rx_empty;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_full) begin
        aw_full <= 1'b1;
        aw_addr <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_full) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_cmd || wr_txd || aw_addr == ADDR_STAT ||
                        aw_addr == ADDR_RXD) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (ar_hs) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      unique case ({s_axi_araddr[7:2], 2'b00})
        ADDR_CMD: s_axi_rdata <= cmd;
        ADDR_RXD: s_axi_rdata <= rx_empty ? 32'h0 : {24'h0, rx_mem[rx_rp]};
        ADDR_STAT: s_axi_rdata <= {27'h0, !rx_empty, tx_full,
                                   state == S_PARK, nack,
                                   !can_cmd};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Command register, launch request
  // ---------------------------------------------------------------
  logic launch, tx_wait;
  assign tx_wait = !is_rd && len != '0 && tx_empty;
  assign launch = pending && !tx_wait &&
                  (state == S_IDLE || state == S_PARK);

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd <= CMD_RESET;
      pending <= 1'b0;
    end else if (wr_cmd) begin
      for (int i = 0; i < 4; i++) begin
        if (w_strb[i]) cmd[8*i +: 8] <= w_data[8*i +: 8] & CMD_MASK[8*i +: 8];
      end
      pending <= 1'b1;
    end else if (launch) begin
      pending <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Transmit and receive FIFOs
  // ---------------------------------------------------------------
  logic step, tx_pop, rx_push;
  assign tx_pop = step && state == S_BYTE && pos == P_DATA && bi == 4'h0 &&
                  q == 2'h0 && !is_rd;
  assign rx_push = step && state == S_BYTE && pos == P_DATA && bi == 4'h8 &&
                   q == 2'h3 && is_rd;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      tx_wp <= '0;
      tx_rp <= '0;
      tx_cnt <= '0;
    end else begin
      if (wr_txd) tx_wp <= tx_wp + 1'b1;
      if (tx_pop) tx_rp <= tx_rp + 1'b1;
      tx_cnt <= tx_cnt + (TAW+1)'(wr_txd) - (TAW+1)'(tx_pop);
    end
  end

  always_ff @(posedge clock) begin
    if (wr_txd) tx_mem[tx_wp] <= w_data[7:0];
    if (rx_push) rx_mem[rx_wp] <= rx_sh;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rx_wp <= '0;
      rx_rp <= '0;
      rx_cnt <= '0;
    end else begin
      if (rx_push) rx_wp <= rx_wp + 1'b1;
      if (rd_rxd) rx_rp <= rx_rp + 1'b1;
      rx_cnt <= rx_cnt + (RAW+1)'(rx_push) - (RAW+1)'(rd_rxd);
    end
  end

  // ---------------------------------------------------------------
  // Byte to send for the current position
  // ---------------------------------------------------------------
  always_comb begin
    unique case (pos)
      P_SB: byte_out = START_BYTE;
      P_A1: begin
        if (at == AT_GCALL) byte_out = GCALL_BYTE;
        else if (at == AT_10) byte_out = {TEN_HDR, addr10[9:8], 1'b0};
        else byte_out = {cmd[CMD_A7_LSB +: 7], cmd[CMD_DIR]};
      end
      P_A2: byte_out = addr10[7:0];
      P_A3: byte_out = {TEN_HDR, addr10[9:8], 1'b1};
      P_DATA: byte_out = tx_mem[tx_rp];
      default: byte_out = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Bus sequencer: quarter-bit timing with slave clock stretching
  // ---------------------------------------------------------------
  logic tick, hold, byte_end, last;
  assign tick = tmr == '0;
  assign hold = (q == 2'h2 && !scl_f) ||
                (state == S_BYTE && pos == P_DATA && bi == 4'h0 &&
                 q == 2'h0 && (is_rd ? rx_full : tx_empty));
  assign step = tick && !hold && (state == S_START || state == S_BYTE ||
                                  state == S_STOP);
  assign byte_end = step && state == S_BYTE && bi == 4'h8 && q == 2'h3;
  assign last = remain == 11'h001;
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oen = !scl_drv;
  assign sda_oen = !sda_drv;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= S_IDLE;
      pos <= P_A1;
      q <= 2'h0;
      bi <= 4'h0;
      tmr <= '0;
      sh <= 8'h00;
      rx_sh <= 8'h00;
      remain <= 11'h000;
      nack <= 1'b0;
      got_nack <= 1'b0;
      scl_drv <= 1'b0;
      sda_drv <= 1'b0;
    end else begin
      if (hold || step || !tick) begin
        tmr <= (hold || step) ? TW'(QTR - 1) : tmr - 1'b1;
      end
      if (step) q <= q + 2'h1;
      if (launch) begin
        state <= S_START;
        pos <= cmd[CMD_SB] ? P_SB : P_A1;
        remain <= len;
        nack <= 1'b0;
        q <= 2'h0;
        tmr <= TW'(QTR - 1);
      end else if (step) begin
        unique case (state)
          S_START: begin
            unique case (q)
              2'h0: sda_drv <= 1'b0;
              2'h1: scl_drv <= 1'b0;
              2'h2: sda_drv <= 1'b1;
              2'h3: begin
                scl_drv <= 1'b1;
                state <= S_BYTE;
                bi <= 4'h0;
              end
            endcase
          end
          S_STOP: begin
            unique case (q)
              2'h0: begin
                scl_drv <= 1'b1;
                sda_drv <= 1'b1;
              end
              2'h1: scl_drv <= 1'b0;
              2'h2: sda_drv <= 1'b0;
              2'h3: state <= S_IDLE;
            endcase
          end
          S_BYTE: begin
            unique case (q)
              2'h0: begin
                if (bi == 4'h0) begin
                  sh <= {byte_out[6:0], 1'b0};
                  sda_drv <= !(pos == P_DATA && is_rd) && !byte_out[7];
                end else if (bi != 4'h8) begin
                  sh <= {sh[6:0], 1'b0};
                  sda_drv <= !(pos == P_DATA && is_rd) && !sh[7];
                end else begin
                  sda_drv <= pos == P_DATA && is_rd && !last;
                end
              end
              2'h1: scl_drv <= 1'b0;
              2'h2: begin
                if (bi == 4'h8) got_nack <= sda_f;
                else rx_sh <= {rx_sh[6:0], sda_f};
              end
              2'h3: begin
                scl_drv <= 1'b1;
                bi <= bi == 4'h8 ? 4'h0 : bi + 4'h1;
              end
            endcase
          end
          default: ;
        endcase
        if (byte_end) begin
          // SDA is left alone here: a release on the falling SCL edge races it
          unique case (pos)
            P_SB: begin
              pos <= P_A1;
              state <= S_START;
            end
            P_A1, P_A2, P_A3: begin
              if (got_nack) begin
                nack <= 1'b1;
                state <= S_STOP;
              end else if (pos == P_A1 && at == AT_10) begin
                pos <= P_A2;
              end else if (pos == P_A2 && is_rd) begin
                pos <= P_A3;
                state <= S_START;
              end else if (remain == '0) begin
                state <= cmd[CMD_STOP] ? S_STOP : S_PARK;
              end else begin
                pos <= P_DATA;
              end
            end
            P_DATA: begin
              remain <= remain - 11'h001;
              if (!is_rd && got_nack && !last) begin
                nack <= 1'b1;
                state <= S_STOP;
              end else if (last) begin
                state <= cmd[CMD_STOP] ? S_STOP : S_PARK;
              end
            end
            default: ;
          endcase
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);

  property p_a7_byte;
    step && state == S_BYTE && bi == 4'h0 && q == 2'h0 && pos == P_A1 &&
    at == AT_7 |=> sh[7:1] == {cmd[CMD_A7_LSB +: 6], cmd[CMD_DIR]};
  endproperty
  a_a7_byte: assert property (p_a7_byte) else $error("bad 7-bit addr");

  property p_gcall;
    step && state == S_BYTE && bi == 4'h0 && q == 2'h0 && pos == P_A1 &&
    at == AT_GCALL |=> sh == 8'h00 && sda_drv && pos == P_A1;
  endproperty
  a_gcall: assert property (p_gcall) else $error("bad general call");

  property p_sb;
    launch |=> state == S_START && (pos == P_SB) == $past(cmd[CMD_SB]);
  endproperty
  a_sb: assert property (p_sb) else $error("start byte choice");

  property p_stop;
    byte_end && pos == P_DATA && last && cmd[CMD_STOP] |=> state == S_STOP;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");

  property p_park;
    state == S_PARK |-> !scl_oen && sda_oen;
  endproperty
  a_park: assert property (p_park) else $error("park not held");

  property p_ack;
    step && state == S_BYTE && pos == P_DATA && is_rd && bi == 4'h8 &&
    q == 2'h0 |=> sda_drv == !$past(last);
  endproperty
  a_ack: assert property (p_ack) else $error("bad read ack");

  property p_rx_hold;
    state == S_BYTE && pos == P_DATA && is_rd && bi == 4'h0 && q == 2'h0 &&
    rx_full |-> !scl_oen && !step;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx overrun");

  property p_tx_wait;
    pending && tx_wait && state == S_IDLE |=> state == S_IDLE;
  endproperty
  a_tx_wait: assert property (p_tx_wait) else $error("start w/o data");

  property p_len;
    launch |=> remain == $past(len);
  endproperty
  a_len: assert property (p_len) else $error("length not loaded");

  property p_rsvd;
    cmd[31:26] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");

  property p_launch;
    wr_cmd |=> pending && (launch || tx_wait);
  endproperty
  a_launch: assert property (p_launch) else $error("no launch");

  property p_tx_pop;
    tx_pop |-> !tx_empty;
  endproperty
  a_tx_pop: assert property (p_tx_pop) else $error("tx underrun");

  c_stop: cover property (byte_end && pos == P_DATA && cmd[CMD_STOP]);
  c_park: cover property (state == S_PARK ##[1:50] launch);
  c_rx_full: cover property (hold && rx_full);
  c_ten: cover property (pos == P_A3 && state == S_BYTE);
endmodule : i2m_master

// ==== tb/i2m_slave_model.sv ====
// Behavioural I2C slave that logs every byte seen on the bus
`timescale 1ns/1ps
module i2m_slave_model #(
  parameter logic [6:0] ADDR7 = 7'h3a,
  parameter logic [1:0] ADDR_HI = 2'h2
) (
  // Bus wires
  input wire logic scl,
  input wire logic sda,
  // Behaviour
  input wire logic stretch,
  input wire logic [7:0] rd_seed,
  // Pulls, high drives the wire low
  output logic scl_low,
  output logic sda_low
);
  logic [8:0] log_q[$];
  int n_start = 0;
  int n_stop = 0;
  int bitc = 0;
  logic [7:0] sh = 0;
  logic [7:0] tx = 0;
  logic first = 0;
  logic rd = 0;
  logic sel = 0;
  logic sending = 0;
  initial begin
    scl_low = 0;
    sda_low = 0;
  end
  // ------------------------------------------------------------
  // Conditions and bits
  // ------------------------------------------------------------
  always @(negedge sda) if (scl === 1'b1) begin
    n_start++;
    bitc = -1;
    first = 1;
    sending = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    n_stop++;
    sel = 0;
    sending = 0;
  end
  // Ninth clock logs the byte with its acknowledge level
  always @(posedge scl) begin
    if (bitc < 8) sh = {sh[6:0], sda};
    else begin
      log_q.push_back({sh, sda});
      if (sda) sending = 0;
    end
  end
  always @(negedge scl) begin
    bitc++;
    if (bitc == 8) begin
      if (first) begin
        rd = sh[0];
        sel = sh[7:1] == ADDR7 || sh == 8'h00 ||
              sh[7:1] == {5'h1e, ADDR_HI};
      end
      sda_low = sel && !sending;
    end else if (bitc == 9) begin
      bitc = 0;
      if (first && sel && rd) begin
        sending = 1;
        tx = rd_seed;
      end else if (sending) tx = tx + 8'h01;
      first = 0;
      sda_low = sending && !tx[7];
      if (stretch) begin
        scl_low = 1;
        #500 scl_low = 0;
      end
    end else if (sending && bitc > 0) sda_low = !tx[7 - bitc];
  end
endmodule : i2m_slave_model

// ==== tb/i2m_master_tb.sv ====
// Self-checking bench of the I2C master command engine
`timescale 1ns/1ps
module i2m_master_tb;
  import i2m_pkg::*;
  localparam logic [6:0] A7 = 7'h3a;
  localparam logic [9:0] A10 = 10'h2c5;
  localparam logic [7:0] HDR = {5'h1e, A10[9:8], 1'b0};
  logic clock = 0;
  logic resetn = 0;
  logic [7:0] aw = 0, ar = 0, s, d;
  logic [31:0] wd = 0, rdat, got;
  logic awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, stretch = 0;
  logic awr, wr, bv, arr, rv, sclo, scloe, sdao, sdaoe, sl, dl;
  logic [1:0] bresp, rresp;
  logic [7:0] seed = 0;
  wire scl = (scloe | sclo) & ~sl;
  wire sda = (sdaoe | sdao) & ~dl;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [1:0] exp_b[$];
  logic [65:0] exp_r[$];
  logic [8:0] exp_bus[$];
  always #4 clock = ~clock;
  i2m_master #(.TX_DEPTH(4), .RX_DEPTH(4)) dut (
    .clock(clock), .resetn(resetn), .s_axi_awaddr(aw), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp),
    .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ar),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .scl_i(scl), .scl_o(sclo), .scl_oen(scloe), .sda_i(sda),
    .sda_o(sdao), .sda_oen(sdaoe));
  i2m_slave_model #(.ADDR7(A7), .ADDR_HI(A10[9:8])) slv (
    .scl(scl), .sda(sda), .stretch(stretch), .rd_seed(seed),
    .scl_low(sl), .sda_low(dl));
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic final_report;
    $display("Checks %0d, errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report
  task automatic wrr(logic [7:0] a, logic [31:0] v, logic [1:0] e);
    logic ta, tw, tb;
    @(posedge clock);
    exp_b.push_back(e);
    aw <= a;
    wd <= v;
    awv <= 1;
    wv <= 1;
    brdy <= 1;
    do begin
      @(negedge clock);
      ta = awv & awr;
      tw = wv & wr;
      tb = bv;
      @(posedge clock);
      if (ta) awv <= 0;
      if (tw) wv <= 0;
    end while (!tb);
    brdy <= 0;
  endtask : wrr
  task automatic rdr(logic [7:0] a, logic [31:0] m, e, logic [1:0] er);
    logic ta, tr;
    @(posedge clock);
    exp_r.push_back({er, m, e});
    ar <= a;
    arv <= 1;
    rrdy <= 1;
    do begin
      @(negedge clock);
      ta = arv & arr;
      tr = rv;
      got = rdat;
      @(posedge clock);
      if (ta) arv <= 0;
    end while (!tr);
    rrdy <= 0;
  endtask : rdr
  task automatic st(int b, logic v);
    do rdr(ADDR_STAT, 0, 0, RESP_OKAY); while (got[b] !== v);
  endtask : st
  task automatic pop(logic [7:0] e);
    st(ST_RXAVAIL, 1);
    rdr(ADDR_RXD, 32'hff, {24'h0, e}, RESP_OKAY);
  endtask : pop
  task automatic push(logic [7:0] v);
    st(ST_TXFULL, 0);
    wrr(ADDR_TXD, {24'h0, v}, RESP_OKAY);
  endtask : push
  function automatic logic [31:0] cmd(logic r, logic [9:0] a, logic sb,
      logic [1:0] at, logic p, logic [10:0] n);
    return {6'h0, n, p, at, sb, a, r};
  endfunction : cmd
  function automatic void eb(logic [7:0] b, logic k);
    exp_bus.push_back({b, k});
  endfunction : eb
  task automatic cnt(int a, int p);
    chk("starts", a, slv.n_start);
    chk("stops", p, slv.n_stop);
  endtask : cnt
  // ------------------------------------------------------------
  // Monitor and timeout
  // ------------------------------------------------------------
  always @(negedge clock) begin
    logic [65:0] x;
    if (bv && brdy) chk("bresp", exp_b.pop_front(), bresp);
    if (rv && rrdy) begin
      x = exp_r.pop_front();
      chk("rresp", x[65:64], rresp);
      chk("rdata", x[31:0], rdat & x[63:32]);
    end
    if (slv.log_q.size() > 0)
      chk("bus byte", exp_bus.pop_front(), slv.log_q.pop_front());
  end
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h9390));
    repeat (6) @(posedge clock);
    resetn <= 1;
    slv.n_start = 0;
    slv.n_stop = 0;
    slv.log_q.delete();
    rdr(ADDR_CMD, '1, CMD_RESET, RESP_OKAY);
    rdr(8'h40, '1, 0, RESP_SLVERR);
    wrr(8'h40, 0, RESP_SLVERR);
    stretch <= 1;
    eb({A7, 1'b0}, 0);
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      eb(d, 0);
      push(d);
    end
    wrr(ADDR_CMD, 32'hfc00_0000 | cmd(0, A7, 0, AT_7, 1, 2), RESP_OKAY);
    wrr(ADDR_CMD, cmd(0, A7, 0, AT_7, 1, 2), RESP_SLVERR);
    st(ST_BUSY, 0);
    rdr(ADDR_CMD, '1, cmd(0, A7, 0, AT_7, 1, 2), RESP_OKAY);
    cnt(1, 1);
    stretch <= 0;
    d = 8'($urandom);
    eb(GCALL_BYTE, 0);
    eb(d, 0);
    push(d);
    wrr(ADDR_CMD, cmd(1, 10'h3ff, 0, AT_GCALL, 1, 1), RESP_OKAY);
    st(ST_BUSY, 0);
    d = 8'($urandom);
    eb(HDR, 0);
    eb(A10[7:0], 0);
    eb(d, 0);
    push(d);
    wrr(ADDR_CMD, cmd(0, A10, 0, AT_10, 0, 1), RESP_OKAY);
    st(ST_BUSY, 0);
    rdr(ADDR_STAT, 32'h4, 32'h4, RESP_OKAY);
    chk("parked scl", 0, scl);
    cnt(3, 2);
    s = 8'($urandom);
    seed <= s;
    eb(HDR, 0);
    eb(A10[7:0], 0);
    eb(HDR | 8'h01, 0);
    eb(s, 0);
    eb(s + 8'h01, 1);
    wrr(ADDR_CMD, cmd(1, A10, 0, AT_10, 1, 2), RESP_OKAY);
    pop(s);
    pop(s + 8'h01);
    st(ST_BUSY, 0);
    cnt(5, 3);
    eb(START_BYTE, 1);
    eb({A7, 1'b1}, 0);
    eb(s, 1);
    wrr(ADDR_CMD, cmd(1, A7, 1, AT_7, 1, 1), RESP_OKAY);
    pop(s);
    st(ST_BUSY, 0);
    cnt(7, 4);
    eb(8'h22, 1);
    wrr(ADDR_CMD, cmd(0, 10'h011, 0, AT_7, 1, 0), RESP_OKAY);
    st(ST_BUSY, 0);
    rdr(ADDR_STAT, 32'h2, 32'h2, RESP_OKAY);
    eb({A7, 1'b1}, 0);
    for (int i = 0; i < 6; i++) eb(s + 8'(i), i == 5);
    wrr(ADDR_CMD, cmd(1, A7, 0, AT_7, 1, 6), RESP_OKAY);
    repeat (1500) @(posedge clock);
    chk("held bytes", 2, exp_bus.size());
    chk("held scl", 0, scl);
    for (int i = 0; i < 6; i++) pop(s + 8'(i));
    st(ST_BUSY, 0);
    cnt(9, 6);
    eb({A7, 1'b0}, 0);
    wrr(ADDR_CMD, cmd(0, A7, 0, AT_7, 1, 6), RESP_OKAY);
    repeat (500) @(posedge clock);
    cnt(9, 6);
    for (int i = 0; i < 6; i++) begin
      d = 8'($urandom);
      eb(d, 0);
      push(d);
    end
    st(ST_BUSY, 0);
    cnt(10, 7);
    final_report();
  end
endmodule : i2m_master_tb
